/* File: rtl/radio_mode_pkg.sv */
// Constants and types for the radio mode control
package radio_mode_pkg;
    // Register addresses
    localparam logic [6:0] ADDR_DEV_STATUS = 7'h02;
    localparam logic [6:0] ADDR_IRQ_STAT1  = 7'h03;
    localparam logic [6:0] ADDR_IRQ_STAT2  = 7'h04;
    localparam logic [6:0] ADDR_IRQ_EN1    = 7'h05;
    localparam logic [6:0] ADDR_IRQ_EN2    = 7'h06;
    localparam logic [6:0] ADDR_MODE_CTRL  = 7'h07;
    localparam logic [6:0] ADDR_XTAL_CTRL  = 7'h62;

    // Operating mode control fields
    localparam int MODE_XTAL_HOLD_BIT = 0;
    localparam int MODE_SYNTH_HOLD_BIT = 1;
    localparam int MODE_RX_REQ_BIT    = 2;
    localparam int MODE_TX_REQ_BIT    = 3;
    localparam int MODE_TEMP_EN_BIT   = 4;
    localparam int MODE_BATT_EN_BIT   = 5;
    localparam int MODE_WAKE_EN_BIT   = 6;
    localparam int MODE_SW_RESET_BIT  = 7;

    // Crystal oscillator control fields
    localparam int XTAL_BUF_EN_BIT  = 0;
    localparam int XTAL_BUF_OVR_BIT = 1;

    // Interrupt status fields
    localparam int STAT1_RX_BIT  = 1;
    localparam int STAT1_TX_BIT  = 2;
    localparam int STAT2_POR_BIT = 0;

    // Reset values
    localparam logic [7:0] MODE_CTRL_RST = 8'h01;
    localparam logic [7:0] XTAL_CTRL_RST = 8'h01;
    localparam logic [7:0] IRQ_EN1_RST   = 8'h00;
    localparam logic [7:0] IRQ_EN2_RST   = 8'h01;

    // Command byte write flag
    localparam int SPI_WRITE_BIT = 7;

    // Device status power state field
    localparam logic [1:0] CPS_IDLE = 2'h0;
    localparam logic [1:0] CPS_RX   = 2'h1;
    localparam logic [1:0] CPS_TX   = 2'h2;

    // Timing in 10 ns cycles
    localparam int SHUTDOWN_RESP_CYC = 1_680_000; // 16.8 ms
    localparam int LOWPWR_RESP_CYC   = 80_000;    // 800 us
    localparam int FAST_RESP_CYC     = 20_000;    // 200 us
    localparam int WAIT_W            = 21;

    typedef enum logic [2:0] {
        ST_SHUTDOWN = 3'b000,
        ST_POR      = 3'b001,
        ST_IDLE     = 3'b010,
        ST_WARMUP   = 3'b011,
        ST_TX       = 3'b100,
        ST_RX       = 3'b101
    } radio_state_t;

    typedef enum logic [2:0] {
        IDLE_STANDBY = 3'b000,
        IDLE_SLEEP   = 3'b001,
        IDLE_SENSOR  = 3'b010,
        IDLE_READY   = 3'b011,
        IDLE_TUNE    = 3'b100
    } idle_mode_t;

    typedef struct packed {
        logic main_reg;
        logic low_power_regulator;
        logic xtal;
        logic xtal_buf;
        logic pll;
        logic pa;
        logic rx;
        logic wake_timer;
        logic batt_mon;
        logic temp_sens;
    } power_ctrl_t;

    typedef struct packed {
        logic sclk;
        logic nsel;
        logic sdi;
        logic shutdown;
    } pins_t;

    localparam pins_t PINS_RST = 4'h4; // Select high, rest low
endpackage : radio_mode_pkg

/* File: rtl/radio_operating_mode_control.sv */
// Radio power and operating mode sequencer with serial register access
//
// How it works
// - Shutdown pin high forces shutdown always
// - Shutdown clears registers, ignores serial access
// - Shutdown pin falling starts power-on reset
// - Resets and shutdown exit land in ready
// - Mode value zero selects standby
// - Standby still allows register reads, writes
// - Wake-timer bit selects sleep mode
// - Sensor mode runs battery, temperature monitors
// - Crystal-hold bit selects ready, crystal on
// - Synth-hold bit selects tune, PLL on
// - Tune forces crystal on automatically
// - Request bits move idle into TX/RX
// - Entry delays: 16.8ms, 800us, 200us
// - Main regulator off only in shutdown, standby, sleep
// - Mode register selects mode, pin shutdown
// - Buffer override holds ready, unless tune, until cleared
// - Interrupt low until its status read
`timescale 1ns/100ps
module radio_operating_mode_control #(
    parameter int SHUTDOWN_RESP_CYC = radio_mode_pkg::SHUTDOWN_RESP_CYC,
    parameter int LOWPWR_RESP_CYC   = radio_mode_pkg::LOWPWR_RESP_CYC,
    parameter int FAST_RESP_CYC     = radio_mode_pkg::FAST_RESP_CYC
) (
    input  wire logic                    mclk_i,            // Clock
    input  wire logic                    arst_n_i,          // Reset
    input  wire logic                    shutdown_pin_i,    // Shutdown
    input  wire logic                    spi_sclk_i,        // Serial clk
    input  wire logic                    spi_nsel_i,        // Select, low
    input  wire logic                    spi_sdi_i,         // Serial in
    output logic                         spi_sdo_o,         // Serial out
    output logic                         spi_sdo_oe_o,      // Out enable
    output logic                         interrupt_out_n_o, // Irq, low
    output radio_mode_pkg::power_ctrl_t  power_ctrl_o,      // Enables
    output radio_mode_pkg::radio_state_t state_o,           // State
    output radio_mode_pkg::idle_mode_t   idle_mode_o        // Idle mode
);
    localparam int WW = radio_mode_pkg::WAIT_W;
    localparam logic [WW-1:0] POR_LOAD =
        WW'(SHUTDOWN_RESP_CYC - FAST_RESP_CYC - 1);
    localparam logic [WW-1:0] LOWPWR_LOAD = WW'(LOWPWR_RESP_CYC - 1);
    localparam logic [WW-1:0] FAST_LOAD   = WW'(FAST_RESP_CYC - 1);

    // Pin synchronisers
    radio_mode_pkg::pins_t meta_q;
    radio_mode_pkg::pins_t sync_q;
    logic                  sclk_prev_q;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_q      <= radio_mode_pkg::PINS_RST;
            sync_q      <= radio_mode_pkg::PINS_RST;
            sclk_prev_q <= 1'b0;
        end else begin
            meta_q      <= '{sclk: spi_sclk_i, nsel: spi_nsel_i,
                             sdi: spi_sdi_i, shutdown: shutdown_pin_i};
            sync_q      <= meta_q;
            sclk_prev_q <= sync_q.sclk;
        end
    end

    radio_mode_pkg::radio_state_t state_q;
    radio_mode_pkg::radio_state_t state_d;
    logic [WW-1:0]                wait_q;
    logic [WW-1:0]                wait_d;

    logic [7:0] mode_ctrl_q;
    logic [7:0] xtal_ctrl_q;
    logic [7:0] irq_en1_q;
    logic [7:0] irq_en2_q;
    logic [7:0] irq_stat1_q;
    logic [7:0] irq_stat2_q;

    // Serial interface
    logic [2:0] bit_cnt_q;
    logic       data_phase_q;
    logic       write_q;
    logic [6:0] addr_q;
    logic [7:0] shift_q;
    logic [7:0] rd_shift_q;
    logic       sdo_q;
    logic       sdo_oe_q;
    logic [7:0] rd_data;

    wire spi_live   = state_q > radio_mode_pkg::ST_POR;
    wire spi_idle   = sync_q.nsel | ~spi_live;
    wire sclk_rise  = ~spi_idle & sync_q.sclk & ~sclk_prev_q;
    wire sclk_fall  = ~spi_idle & ~sync_q.sclk & sclk_prev_q;
    wire [7:0] rx_byte   = {shift_q[6:0], sync_q.sdi};
    wire       byte_done = sclk_rise & (bit_cnt_q == 3'h7);
    wire       addr_done = byte_done & ~data_phase_q;
    wire       data_done = byte_done & data_phase_q;
    wire       cmd_write = rx_byte[radio_mode_pkg::SPI_WRITE_BIT];
    wire       wr_stb    = data_done & write_q;
    wire       rd_stb    = (addr_done & ~cmd_write) | (data_done & ~write_q);
    wire [6:0] next_addr = addr_q + 7'h01;
    wire [6:0] rd_addr   = data_phase_q ? next_addr : rx_byte[6:0];

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bit_cnt_q    <= 3'h0;
            data_phase_q <= 1'b0;
            write_q      <= 1'b0;
            addr_q       <= 7'h00;
            shift_q      <= 8'h00;
            rd_shift_q   <= 8'h00;
            sdo_q        <= 1'b0;
            sdo_oe_q     <= 1'b0;
        end else begin
            sdo_oe_q <= ~spi_idle & data_phase_q & ~write_q;
            if (spi_idle) begin
                bit_cnt_q    <= 3'h0;
                data_phase_q <= 1'b0;
            end else begin
                if (sclk_rise) begin
                    shift_q   <= rx_byte;
                    bit_cnt_q <= bit_cnt_q + 3'h1;
                end
                if (addr_done) begin
                    data_phase_q <= 1'b1;
                    write_q      <= cmd_write;
                end
                if (byte_done) begin
                    addr_q <= addr_done ? rx_byte[6:0] : next_addr;
                end
                if (rd_stb) begin
                    rd_shift_q <= rd_data;
                end else if (sclk_fall) begin
                    sdo_q      <= rd_shift_q[7];
                    rd_shift_q <= {rd_shift_q[6:0], 1'b0};
                end
            end
        end
    end

    // Read data selection
    logic [1:0] cps;
    assign cps = (state_q == radio_mode_pkg::ST_TX) ? radio_mode_pkg::CPS_TX :
                 (state_q == radio_mode_pkg::ST_RX) ? radio_mode_pkg::CPS_RX :
                 radio_mode_pkg::CPS_IDLE;

    always_comb begin
        case (rd_addr)
            radio_mode_pkg::ADDR_DEV_STATUS: rd_data = {6'h00, cps};
            radio_mode_pkg::ADDR_IRQ_STAT1:  rd_data = irq_stat1_q;
            radio_mode_pkg::ADDR_IRQ_STAT2:  rd_data = irq_stat2_q;
            radio_mode_pkg::ADDR_IRQ_EN1:    rd_data = irq_en1_q;
            radio_mode_pkg::ADDR_IRQ_EN2:    rd_data = irq_en2_q;
            radio_mode_pkg::ADDR_MODE_CTRL:  rd_data = mode_ctrl_q;
            radio_mode_pkg::ADDR_XTAL_CTRL:  rd_data = xtal_ctrl_q;
            default:                         rd_data = 8'h00;
        endcase
    end

    // Register file
    wire sw_reset = wr_stb && (addr_q == radio_mode_pkg::ADDR_MODE_CTRL) &&
                    rx_byte[radio_mode_pkg::MODE_SW_RESET_BIT];
    wire regs_lost = ~spi_live | sw_reset;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_ctrl_q <= radio_mode_pkg::MODE_CTRL_RST;
            xtal_ctrl_q <= radio_mode_pkg::XTAL_CTRL_RST;
            irq_en1_q   <= radio_mode_pkg::IRQ_EN1_RST;
            irq_en2_q   <= radio_mode_pkg::IRQ_EN2_RST;
        end else if (regs_lost) begin
            mode_ctrl_q <= radio_mode_pkg::MODE_CTRL_RST;
            xtal_ctrl_q <= radio_mode_pkg::XTAL_CTRL_RST;
            irq_en1_q   <= radio_mode_pkg::IRQ_EN1_RST;
            irq_en2_q   <= radio_mode_pkg::IRQ_EN2_RST;
        end else if (wr_stb) begin
            case (addr_q)
                radio_mode_pkg::ADDR_MODE_CTRL: mode_ctrl_q <= rx_byte;
                radio_mode_pkg::ADDR_XTAL_CTRL: xtal_ctrl_q <= rx_byte;
                radio_mode_pkg::ADDR_IRQ_EN1:   irq_en1_q   <= rx_byte;
                radio_mode_pkg::ADDR_IRQ_EN2:   irq_en2_q   <= rx_byte;
                default: ;
            endcase
        end
    end

    // Interrupt status: reading clears enabled bits, new events win
    logic       por_done;
    logic       tx_entered;
    logic       rx_entered;
    wire  [7:0] clr1 = (rd_stb && rd_addr == radio_mode_pkg::ADDR_IRQ_STAT1) ?
                       irq_en1_q : 8'h00;
    wire  [7:0] clr2 = (rd_stb && rd_addr == radio_mode_pkg::ADDR_IRQ_STAT2) ?
                       irq_en2_q : 8'h00;
    wire  [7:0] set1 = (8'(tx_entered) << radio_mode_pkg::STAT1_TX_BIT) |
                       (8'(rx_entered) << radio_mode_pkg::STAT1_RX_BIT);
    wire  [7:0] set2 = 8'(por_done | sw_reset) << radio_mode_pkg::STAT2_POR_BIT;
    wire  [7:0] stat1_d = (regs_lost ? 8'h00 : (irq_stat1_q & ~clr1)) | set1;
    wire  [7:0] stat2_d = (regs_lost ? 8'h00 : (irq_stat2_q & ~clr2)) | set2;
    wire        irq_pend = |({stat1_d, stat2_d} & {irq_en1_q, irq_en2_q});
    logic       irq_n_q;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_stat1_q <= 8'h00;
            irq_stat2_q <= 8'h00;
            irq_n_q     <= 1'b1;
        end else begin
            irq_stat1_q <= stat1_d;
            irq_stat2_q <= stat2_d;
            irq_n_q     <= ~irq_pend;
        end
    end

    // Idle mode selection
    wire tx_req   = mode_ctrl_q[radio_mode_pkg::MODE_TX_REQ_BIT];
    wire rx_req   = mode_ctrl_q[radio_mode_pkg::MODE_RX_REQ_BIT];
    wire any_req  = tx_req | rx_req;
    wire synth_hd = mode_ctrl_q[radio_mode_pkg::MODE_SYNTH_HOLD_BIT];
    wire xtal_hd  = mode_ctrl_q[radio_mode_pkg::MODE_XTAL_HOLD_BIT];
    wire wake_en  = mode_ctrl_q[radio_mode_pkg::MODE_WAKE_EN_BIT];
    wire batt_en  = mode_ctrl_q[radio_mode_pkg::MODE_BATT_EN_BIT];
    wire temp_en  = mode_ctrl_q[radio_mode_pkg::MODE_TEMP_EN_BIT];
    wire buf_ovr  = xtal_ctrl_q[radio_mode_pkg::XTAL_BUF_OVR_BIT];
    wire buf_en   = xtal_ctrl_q[radio_mode_pkg::XTAL_BUF_EN_BIT];

    radio_mode_pkg::idle_mode_t sel_raw;
    radio_mode_pkg::idle_mode_t idle_mode;
    assign sel_raw =
        synth_hd            ? radio_mode_pkg::IDLE_TUNE :
        xtal_hd             ? radio_mode_pkg::IDLE_READY :
        (batt_en | temp_en) ? radio_mode_pkg::IDLE_SENSOR :
        wake_en             ? radio_mode_pkg::IDLE_SLEEP :
        radio_mode_pkg::IDLE_STANDBY;
    assign idle_mode = (buf_ovr && sel_raw != radio_mode_pkg::IDLE_TUNE) ?
                       radio_mode_pkg::IDLE_READY : sel_raw;
    wire fast_idle = (idle_mode == radio_mode_pkg::IDLE_READY) ||
                     (idle_mode == radio_mode_pkg::IDLE_TUNE);
    wire [WW-1:0] entry_load = fast_idle ? FAST_LOAD : LOWPWR_LOAD;

    // Radio state machine
    always_comb begin
        state_d     = state_q;
        wait_d      = wait_q;
        por_done    = 1'b0;
        tx_entered  = 1'b0;
        rx_entered  = 1'b0;
        case (state_q)
            radio_mode_pkg::ST_SHUTDOWN: begin
                if (!sync_q.shutdown) begin
                    state_d = radio_mode_pkg::ST_POR;
                    wait_d  = POR_LOAD;
                end
            end
            radio_mode_pkg::ST_POR: begin
                if (wait_q == '0) begin
                    state_d  = radio_mode_pkg::ST_IDLE;
                    por_done = 1'b1;
                end else begin
                    wait_d = wait_q - WW'(1);
                end
            end
            radio_mode_pkg::ST_IDLE: begin
                if (any_req) begin
                    state_d = radio_mode_pkg::ST_WARMUP;
                    wait_d  = entry_load;
                end
            end
            radio_mode_pkg::ST_WARMUP: begin
                if (!any_req) begin
                    state_d = radio_mode_pkg::ST_IDLE;
                end else if (wait_q == '0) begin
                    state_d    = tx_req ? radio_mode_pkg::ST_TX :
                                          radio_mode_pkg::ST_RX;
                    tx_entered = tx_req;
                    rx_entered = ~tx_req;
                end else begin
                    wait_d = wait_q - WW'(1);
                end
            end
            radio_mode_pkg::ST_TX, radio_mode_pkg::ST_RX: begin
                if (!any_req) begin
                    state_d = radio_mode_pkg::ST_IDLE;
                end else if (tx_req != (state_q == radio_mode_pkg::ST_TX)) begin
                    state_d = radio_mode_pkg::ST_WARMUP;
                    wait_d  = FAST_LOAD;
                end
            end
            default: state_d = radio_mode_pkg::ST_SHUTDOWN;
        endcase
        if (sync_q.shutdown) begin
            state_d = radio_mode_pkg::ST_SHUTDOWN;
        end else if (sw_reset) begin
            state_d = radio_mode_pkg::ST_IDLE;
        end
    end

    // Block enables
    wire powered = state_q != radio_mode_pkg::ST_SHUTDOWN;
    wire in_idle = state_q == radio_mode_pkg::ST_IDLE;
    wire active  = state_q > radio_mode_pkg::ST_IDLE;
    wire lp_only = (idle_mode == radio_mode_pkg::IDLE_STANDBY) ||
                   (idle_mode == radio_mode_pkg::IDLE_SLEEP);
    wire xtal_on = active | (in_idle & fast_idle);

    radio_mode_pkg::power_ctrl_t pc_d;
    assign pc_d.main_reg = (state_q == radio_mode_pkg::ST_POR) | active |
                           (in_idle & ~lp_only);
    assign pc_d.low_power_regulator = powered;
    assign pc_d.xtal       = xtal_on;
    assign pc_d.xtal_buf   = xtal_on & (~buf_ovr | buf_en);
    assign pc_d.pll        = active |
                             (in_idle && idle_mode == radio_mode_pkg::IDLE_TUNE);
    assign pc_d.pa         = state_q == radio_mode_pkg::ST_TX;
    assign pc_d.rx         = state_q == radio_mode_pkg::ST_RX;
    assign pc_d.wake_timer = spi_live & wake_en;
    assign pc_d.batt_mon   = spi_live & batt_en;
    assign pc_d.temp_sens  = spi_live & temp_en;

    radio_mode_pkg::power_ctrl_t pc_q;
    radio_mode_pkg::idle_mode_t  idle_mode_q;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q     <= radio_mode_pkg::ST_SHUTDOWN;
            wait_q      <= '0;
            pc_q        <= '0;
            idle_mode_q <= radio_mode_pkg::IDLE_READY;
        end else begin
            state_q     <= state_d;
            wait_q      <= wait_d;
            pc_q        <= pc_d;
            idle_mode_q <= idle_mode;
        end
    end

    assign spi_sdo_o         = sdo_q;
    assign spi_sdo_oe_o      = sdo_oe_q;
    assign interrupt_out_n_o = irq_n_q;
    assign power_ctrl_o      = pc_q;
    assign state_o           = state_q;
    assign idle_mode_o       = idle_mode_q;
endmodule : radio_operating_mode_control

/* File: tb/radio_mode_sva.sv */
// Assertion checker for the radio operating mode control
`timescale 1ns/100ps
module radio_mode_sva #(
    parameter int SHUTDOWN_RESP_CYC = 300,
    parameter int LOWPWR_RESP_CYC   = 100,
    parameter int FAST_RESP_CYC     = 40
) (
    input wire logic                         mclk_i,            // Clock
    input wire logic                         arst_n_i,          // Reset
    input wire logic                         shutdown_pin_i,    // Shutdown
    input wire logic                         spi_sclk_i,        // Serial clk
    input wire logic                         spi_nsel_i,        // Select
    input wire logic                         spi_sdi_i,         // Serial in
    input wire logic                         spi_sdo_o,         // Serial out
    input wire logic                         spi_sdo_oe_o,      // Out enable
    input wire logic                         interrupt_out_n_o, // Irq, low
    input wire radio_mode_pkg::power_ctrl_t  power_ctrl_o,      // Enables
    input wire radio_mode_pkg::radio_state_t state_o,           // State
    input wire radio_mode_pkg::idle_mode_t   idle_mode_o        // Idle mode
);
    localparam int POR_CYC = SHUTDOWN_RESP_CYC - FAST_RESP_CYC;
    radio_mode_pkg::radio_state_t pst_q;
    radio_mode_pkg::idle_mode_t   pmd_q;
    logic [31:0]                  cnt_q;
    logic                         slow_q;
    wire steady = state_o == pst_q && idle_mode_o == pmd_q;
    wire idl = steady && state_o == radio_mode_pkg::ST_IDLE;
    wire live = state_o > radio_mode_pkg::ST_POR;
    wire [31:0] warm = slow_q ? LOWPWR_RESP_CYC : FAST_RESP_CYC;
    // State age and warmup pace
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pst_q  <= radio_mode_pkg::ST_SHUTDOWN;
            pmd_q  <= radio_mode_pkg::IDLE_READY;
            cnt_q  <= 32'h0;
            slow_q <= 1'b0;
        end else begin
            pst_q  <= state_o;
            pmd_q  <= idle_mode_o;
            cnt_q  <= (state_o == pst_q) ? cnt_q + 32'h1 : 32'h1;
            if (state_o != pst_q) slow_q <= pst_q == radio_mode_pkg::ST_IDLE
                && pmd_q < radio_mode_pkg::IDLE_READY;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_por_exit;
        state_o == radio_mode_pkg::ST_POR ##1
        state_o == radio_mode_pkg::ST_IDLE;
    endsequence
    sequence s_warm_exit;
        state_o == radio_mode_pkg::ST_WARMUP ##1
        state_o[2];
    endsequence
    a_shutdown_forces_off: assert property (
        shutdown_pin_i [*5] |-> state_o == radio_mode_pkg::ST_SHUTDOWN)
        else $error("shutdown not forced");
    a_no_access_off: assert property (
        !live && $past(!live) |-> !spi_sdo_oe_o)
        else $error("output driven while off");
    a_por_lands_ready: assert property (
        s_por_exit |-> idle_mode_o == radio_mode_pkg::IDLE_READY)
        else $error("reset not in ready");
    a_por_length: assert property (
        s_por_exit |-> cnt_q inside {[POR_CYC - 1:POR_CYC + 1]})
        else $error("reset length wrong");
    a_warmup_length: assert property (
        s_warm_exit |-> cnt_q + 32'h1 >= warm && cnt_q <= warm + 32'h1)
        else $error("warmup length wrong");
    a_main_regulator: assert property (
        idl |-> power_ctrl_o.main_reg == (idle_mode_o >
        radio_mode_pkg::IDLE_SLEEP)) else $error("main regulator wrong");
    a_tune_xtal_on: assert property (
        idl && idle_mode_o == radio_mode_pkg::IDLE_TUNE
        |-> power_ctrl_o.xtal && power_ctrl_o.pll)
        else $error("tune enables wrong");
    a_ready_xtal: assert property (
        idl && idle_mode_o == radio_mode_pkg::IDLE_READY
        |-> power_ctrl_o.xtal && !power_ctrl_o.pll)
        else $error("ready enables wrong");
    a_standby_quiet: assert property (
        idl && idle_mode_o == radio_mode_pkg::IDLE_STANDBY
        |-> power_ctrl_o.low_power_regulator && !power_ctrl_o.xtal)
        else $error("standby enables wrong");
    a_sleep_wake: assert property (
        idl && idle_mode_o == radio_mode_pkg::IDLE_SLEEP
        |-> power_ctrl_o.wake_timer && !power_ctrl_o.xtal)
        else $error("sleep enables wrong");
    a_active_path: assert property (
        steady && state_o[2]
        |-> power_ctrl_o.pa == !state_o[0] && power_ctrl_o.rx == state_o[0])
        else $error("path wrong");
endmodule : radio_mode_sva
bind radio_operating_mode_control radio_mode_sva #(
    .SHUTDOWN_RESP_CYC(SHUTDOWN_RESP_CYC),
    .LOWPWR_RESP_CYC  (LOWPWR_RESP_CYC),
    .FAST_RESP_CYC    (FAST_RESP_CYC)
) radio_mode_sva_inst (.*);

/* File: tb/spi_host_model.sv */
// Host side serial master model
`timescale 1ns/100ps
module spi_host_model (
    input  wire logic mclk_i,   // Clock
    input  wire logic sdo_i,    // Device data
    input  wire logic sdo_oe_i, // Device drives data
    output logic      sclk_o,   // Serial clock
    output logic      sel_n_o,  // Select, low
    output logic      sdi_o     // Data to device
);
    logic last_q;
    initial begin
        sclk_o  = 1'b0;
        sel_n_o = 1'b1;
        sdi_o   = 1'b0;
        last_q  = 1'b0;
    end
    // 160 ns per bit; the clock stands low outside frames
    task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            @(negedge mclk_i) sdi_o = tx[i];
            repeat (7) @(negedge mclk_i);
            // Undriven line reads as inverse of last bit
            rx[i]  = sdo_oe_i ? sdo_i : ~last_q;
            last_q = rx[i];
            sclk_o = 1'b1;
            repeat (8) @(negedge mclk_i);
            sclk_o = 1'b0;
        end
    endtask : shift
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
                        output logic [7:0] rd);
        logic [7:0] junk;
        @(negedge mclk_i) sel_n_o = 1'b0;
        shift(cmd, junk);
        shift(wd, rd);
        repeat (8) @(negedge mclk_i);
        sel_n_o = 1'b1;
        sdi_o   = ~sdi_o;
        repeat (16) @(negedge mclk_i);
    endtask : xfer
endmodule : spi_host_model

/* File: tb/radio_operating_mode_control_tb.sv */
// Self-checking bench for the radio operating mode control
`timescale 1ns/100ps
module radio_operating_mode_control_tb;
    logic                         mclk, arst_n, shutdown_pin, sclk, nsel_n, sdi;
    logic                         sdo, oe, irq_n;
    logic [7:0]                   m;
    radio_mode_pkg::power_ctrl_t  pwr;
    radio_mode_pkg::radio_state_t st;
    radio_mode_pkg::idle_mode_t   md;
    int                           n_mismatch = 0;
    int                           cmp_count = 0;
    int                           seed = 34137;
    int                           n;
    localparam logic [6:0] MODE_A = radio_mode_pkg::ADDR_MODE_CTRL;
    localparam logic [6:0] XTAL_A = radio_mode_pkg::ADDR_XTAL_CTRL;
    localparam logic [6:0] STAT_A = radio_mode_pkg::ADDR_DEV_STATUS;
    logic [7:0] tbl [6] = '{8'h00, 8'h40, 8'h20, 8'h10, 8'h01, 8'h02};
    radio_operating_mode_control #(
        .SHUTDOWN_RESP_CYC(300),
        .LOWPWR_RESP_CYC  (100),
        .FAST_RESP_CYC    (40)
    ) radio_operating_mode_control_inst (
        .mclk_i(mclk), .arst_n_i(arst_n), .shutdown_pin_i(shutdown_pin),
        .spi_sclk_i(sclk), .spi_nsel_i(nsel_n), .spi_sdi_i(sdi),
        .spi_sdo_o(sdo), .spi_sdo_oe_o(oe), .interrupt_out_n_o(irq_n),
        .power_ctrl_o(pwr), .state_o(st), .idle_mode_o(md)
    );
    spi_host_model spi_host_model_inst (
        .mclk_i(mclk), .sdo_i(sdo), .sdo_oe_i(oe),
        .sclk_o(sclk), .sel_n_o(nsel_n), .sdi_o(sdi)
    );
    task automatic check(input string what, input logic [7:0] got,
                         input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic give_verdict;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] junk;
        spi_host_model_inst.xfer({1'b1, a}, d, junk);
    endtask : wr
    task automatic rdc(input logic [6:0] a, input string w,
                       input logic [7:0] e);
        logic [7:0] rd;
        spi_host_model_inst.xfer({1'b0, a}, 8'h00, rd);
        check(w, rd, e);
    endtask : rdc
    task automatic wait_st(input radio_mode_pkg::radio_state_t s,
                           input int lim);
        n = 0;
        while (st !== s) begin
            @(negedge mclk);
            n++;
            if (n > lim) begin
                n_mismatch++;
                give_verdict();
            end
        end
    endtask : wait_st
    function automatic radio_mode_pkg::idle_mode_t exp_mode(logic [7:0] v);
        if (v[1]) return radio_mode_pkg::IDLE_TUNE;
        if (v[0]) return radio_mode_pkg::IDLE_READY;
        if (v[5] | v[4]) return radio_mode_pkg::IDLE_SENSOR;
        if (v[6]) return radio_mode_pkg::IDLE_SLEEP;
        return radio_mode_pkg::IDLE_STANDBY;
    endfunction : exp_mode
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        arst_n = 1'b0;
        shutdown_pin    = 1'b0;
        repeat (10) @(negedge mclk);
        arst_n = 1'b1;
        wait_st(radio_mode_pkg::ST_IDLE, 400);
        check("idle_mode", md, radio_mode_pkg::IDLE_READY);
        repeat (3) @(negedge mclk);
        check("xtal_buf", pwr.xtal_buf, 1'b1);
        check("irq_n", irq_n, 1'b0);
        rdc(radio_mode_pkg::ADDR_IRQ_STAT2, "stat2", 8'h01);
        check("irq_n", irq_n, 1'b1);
        rdc(MODE_A, "mode_rst", radio_mode_pkg::MODE_CTRL_RST);
        rdc(XTAL_A, "xtal_rst", radio_mode_pkg::XTAL_CTRL_RST);
        rdc(7'h10, "unmapped", 8'h00);
        for (int i = 0; i < 14; i++) begin
            m = i < 6 ? tbl[i] : (8'($random(seed)) & 8'h73);
            wr(MODE_A, m);
            check("idle_mode", md, exp_mode(m));
            rdc(MODE_A, "mode_back", m);
        end
        wr(MODE_A, 8'h01);
        wr(XTAL_A, 8'h02);
        check("buf_off", pwr.xtal_buf, 1'b0);
        wr(MODE_A, 8'h00);
        check("held_ready", md, radio_mode_pkg::IDLE_READY);
        wr(XTAL_A, 8'h00);
        check("standby", md, radio_mode_pkg::IDLE_STANDBY);
        wr(MODE_A, 8'h08);
        wait_st(radio_mode_pkg::ST_TX, 150);
        rdc(STAT_A, "cps_tx", {6'h00, radio_mode_pkg::CPS_TX});
        rdc(radio_mode_pkg::ADDR_IRQ_STAT1, "tx_flag", 8'h04);
        wr(MODE_A, 8'h04);
        wait_st(radio_mode_pkg::ST_RX, 90);
        rdc(STAT_A, "cps_rx", {6'h00, radio_mode_pkg::CPS_RX});
        wr(MODE_A, 8'h01);
        check("back_idle", st, radio_mode_pkg::ST_IDLE);
        wr(MODE_A, 8'h06);
        wait_st(radio_mode_pkg::ST_RX, 90);
        wr(MODE_A, 8'h80);
        check("swr_state", st, radio_mode_pkg::ST_IDLE);
        check("swr_mode", md, radio_mode_pkg::IDLE_READY);
        wr(MODE_A, 8'h40);
        shutdown_pin = 1'b1;
        repeat (6) @(negedge mclk);
        check("off", st, radio_mode_pkg::ST_SHUTDOWN);
        wr(MODE_A, 8'h00);
        shutdown_pin = 1'b0;
        wait_st(radio_mode_pkg::ST_POR, 10);
        wait_st(radio_mode_pkg::ST_IDLE, 400);
        rdc(MODE_A, "lost_regs", radio_mode_pkg::MODE_CTRL_RST);
        give_verdict();
    end
endmodule : radio_operating_mode_control_tb
